// file: adc_channel_ref_result_regs.sv
// Functional notes
// - result bits 3..0 appear in bits 7..4 of the read-only low result register.
// - result bits 11..4 fill all eight bits of the read-only high result register.
// - channel code is the top bit at position 3 above the 4-bit field in bits 7..4.
// - codes 0..11 and 16..22 route the matching external input pin to the converter.
// - code 12 picks bandgap, 14 ground, 15 quarter supply; 13 and 23 are reserved.
// - reference bit 0 uses the supply as reference, 1 uses the bandgap voltage.
// - bandgap level field 00 gives 1.22 V, 01 gives 2.54 V, 10 and 11 are reserved.
// - a pin whose 2-bit mode field is 11 is connected to the converter input path.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module adc_channel_ref_result_regs
  import adc_sel_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  input  wire logic                  clk_en_in,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  input  wire logic [11:0]           conv_result_in,
  input  wire logic                  conv_done_in,
  input  wire logic [2*NUM_PINS-1:0] pin_mode_field_in,
  output logic [4:0]                 channel_code_out,
  output logic                       pin_route_en_out,
  output logic [4:0]                 pin_index_out,
  output analog_src_t                analog_src_out,
  output logic                       reference_source_bit_out,
  output logic [1:0]                 bandgap_level_field_out,
  output logic                       bandgap_level_conflict_out,
  output logic [NUM_PINS-1:0]        pin_analog_en_out
);

  localparam logic [4:0] RST_CODE = {INPUT_SEL_RST[CH_TOP_BIT],
                                     INPUT_SEL_RST[CH_LOW_MSB:CH_LOW_LSB]};

  logic [7:0]        input_select_register_r;
  logic [11:0]       result_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_held_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_held_r;
  logic              wr_fire;
  logic [1:0]        wr_resp;
  logic              sel_write;
  logic [4:0]        ch_code;

  function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] addr,
                                          input logic [11:0]       res,
                                          input logic [7:0]        sel);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_RESULT_LOW:  v[RES_LOW_MSB:RES_LOW_LSB] = res[RES_NIB_MSB:0];
      ADDR_RESULT_HIGH: v = res[RES_HIGH_MSB:RES_HIGH_LSB];
      ADDR_INPUT_SEL:   v = sel;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // only whole aligned words hit a register; any other byte address is unmapped
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == ADDR_RESULT_LOW) || (addr == ADDR_RESULT_HIGH) || (addr == ADDR_INPUT_SEL);
  endfunction

  // lone top bit sits above the 4-bit field
  function automatic logic [4:0] sel_code(input logic [7:0] sel);
    return {sel[CH_TOP_BIT], sel[CH_LOW_MSB:CH_LOW_LSB]};
  endfunction

  function automatic logic is_pin_code(input logic [4:0] code);
    return (code <= CH_EXT_LO_LAST) || (code >= CH_EXT_HI_FIRST && code <= CH_EXT_HI_LAST);
  endfunction

  function automatic analog_src_t src_for_code(input logic [4:0] code);
    analog_src_t s;
    s = SRC_GROUND;
    if (is_pin_code(code)) begin
      s = SRC_PIN;
    end else begin
      case (code)
        CH_BANDGAP:     s = SRC_BANDGAP;
        CH_GROUND:      s = SRC_GROUND;
        CH_QUARTER_VCC: s = SRC_QUARTER_VCC;
        // reserved codes park the input on ground rather than float
        default:        s = SRC_GROUND;
      endcase
    end
    return s;
  endfunction

  // write channel: address and data captured independently, answered once both held
  assign s_axi_awready_out = clk_en_in && !aw_held_r && !s_axi_bvalid_out;
  assign s_axi_wready_out  = clk_en_in && !w_held_r && !s_axi_bvalid_out;
  assign wr_fire           = aw_held_r && w_held_r && !s_axi_bvalid_out;

  always_comb begin
    if (!addr_mapped(aw_addr_r)) begin
      wr_resp = RESP_DECERR;
    end else if (aw_addr_r != ADDR_INPUT_SEL) begin
      wr_resp = RESP_SLVERR;
    end else begin
      wr_resp = RESP_OKAY;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 10'h000;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else if (clk_en_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (clk_en_in) begin
      if (wr_fire) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_resp;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // only the select register is writable; result registers ignore writes
  assign sel_write = clk_en_in && wr_fire && aw_addr_r == ADDR_INPUT_SEL && w_strb_r[0];

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      input_select_register_r <= INPUT_SEL_RST;
    end else if (sel_write) begin
      input_select_register_r <= w_data_r[SEL_BYTE_MSB:0];
    end
  end

  // result captured from the converter only; reads never touch it
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_r <= 12'h000;
    end else if (clk_en_in && conv_done_in) begin
      result_r <= conv_result_in;
    end
  end

  // read channel: one outstanding read, data registered
  assign s_axi_arready_out = clk_en_in && !s_axi_rvalid_out;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (clk_en_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= {24'h000000,
                             reg_read(s_axi_araddr_in, result_r, input_select_register_r)};
        s_axi_rresp_out  <= addr_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  assign ch_code = sel_code(input_select_register_r);
  assign channel_code_out = ch_code;

  // decoded as the word is stored, so the input mux never sees a decode glitch
  // reset values must track the decode of the reset select word
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_route_en_out <= 1'b0;
      pin_index_out    <= RST_CODE;
      analog_src_out   <= SRC_QUARTER_VCC;
    end else if (sel_write) begin
      pin_route_en_out <= is_pin_code(sel_code(w_data_r[SEL_BYTE_MSB:0]));
      pin_index_out    <= sel_code(w_data_r[SEL_BYTE_MSB:0]);
      analog_src_out   <= src_for_code(sel_code(w_data_r[SEL_BYTE_MSB:0]));
    end
  end

  assign reference_source_bit_out = input_select_register_r[REF_SRC_BIT];
  assign bandgap_level_field_out  = input_select_register_r[BG_LEVEL_MSB:BG_LEVEL_LSB];
  // flagged, not blocked: software owns this constraint
  assign bandgap_level_conflict_out = reference_source_bit_out &&
                                      bandgap_level_field_out == BG_1V22;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_analog_en_out[i] = (pin_mode_field_in[2*i +: 2] == PIN_MODE_ANALOG);
    end
  end

endmodule
`default_nettype wire

// file: adc_channel_ref_result_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_channel_ref_result_regs_bench;
  import adc_sel_pkg::*;
  logic clk_sys_in = 0, rstn_in = 0, clk_en_in = 1, conv_done_in, start = 0;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 1, s_axi_arvalid_in = 0;
  logic s_axi_rready_in = 1, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, pin_route_en_out;
  logic reference_source_bit_out, bandgap_level_conflict_out;
  logic [ADDR_W-1:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, pin_analog_en_out;
  logic [3:0] s_axi_wstrb_in = 0, dly = 1;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, bandgap_level_field_out;
  logic [11:0] conv_result_in, value = 0;
  logic [63:0] pin_mode_field_in = 0;
  logic [4:0] channel_code_out, pin_index_out;
  analog_src_t analog_src_out;
  int mismatches = 0, checks_done = 0, cycles = 0;
  adc_channel_ref_result_regs u_dut (.*);
  adc_core_model u_core (.clk_sys_in, .rstn_in, .start_in(start), .value_in(value),
    .delay_in(dly), .result_out(conv_result_in), .done_out(conv_done_in));
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (++cycles > 3000) begin
    mismatches++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // readies sampled at the falling edge, released only after the taking edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w, b;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      aw = s_axi_awvalid_in && s_axi_awready_out;
      w = s_axi_wvalid_in && s_axi_wready_out;
      b = s_axi_bvalid_out;
      if (b) check(s_axi_bresp_out, er);
      @(posedge clk_sys_in);
      if (aw) s_axi_awvalid_in <= 1'b0;
      if (w) s_axi_wvalid_in <= 1'b0;
    end while (!b);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      ar = s_axi_arvalid_in && s_axi_arready_out;
      r = s_axi_rvalid_out;
      if (r) check(s_axi_rdata_out, ed);
      if (r) check(s_axi_rresp_out, er);
      @(posedge clk_sys_in);
      if (ar) s_axi_arvalid_in <= 1'b0;
    end while (!r);
  endtask
  task automatic t_channels();
    logic [4:0] c;
    for (int i = 0; i < 24; i++) begin
      c = i[4:0];
      wr(ADDR_INPUT_SEL, {c[3:0], c[4], 3'h0}, 4'h1, RESP_OKAY);
      check(channel_code_out, c);
      check(pin_route_en_out, c <= 11 || c inside {[16:22]});
      check(pin_index_out, c);
      check(analog_src_out, c == 12 ? SRC_BANDGAP : c == 15 ? SRC_QUARTER_VCC :
        c <= 11 || c inside {[16:22]} ? SRC_PIN : SRC_GROUND);
    end
    $display("channel codes finished");
  endtask
  task automatic t_reference();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_INPUT_SEL, 8'hf0 | i[7:0], 4'h1, RESP_OKAY);
      check(reference_source_bit_out, i[2]);
      check(bandgap_level_field_out, i[1:0]);
      check(bandgap_level_conflict_out, i == 4);
      rd(ADDR_INPUT_SEL, 32'hf0 | i, RESP_OKAY);
    end
    $display("reference finished");
  endtask
  task automatic t_result();
    wr(ADDR_INPUT_SEL, 8'h4d, 4'h1, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      value <= k ? 12'h3c9 : 12'ha5e;
      dly <= k ? 4'h9 : 4'h1;
      start <= 1'b1;
      @(posedge clk_sys_in);
      start <= 1'b0;
      do @(negedge clk_sys_in); while (!conv_done_in);
      @(posedge clk_sys_in);
      rd(ADDR_RESULT_LOW, {24'h0, value[3:0], 4'h0}, RESP_OKAY);
      rd(ADDR_RESULT_HIGH, {24'h0, value[11:4]}, RESP_OKAY);
    end
    wr(ADDR_RESULT_HIGH, 8'h00, 4'h1, RESP_SLVERR);
    rd(ADDR_RESULT_HIGH, {24'h0, value[11:4]}, RESP_OKAY);
    rd(10'h2b0, 32'h0, RESP_DECERR);
    wr(ADDR_INPUT_SEL, 8'h00, 4'h0, RESP_OKAY);
    rd(ADDR_INPUT_SEL, 32'h4d, RESP_OKAY);
    check(channel_code_out, 5'h14);
    $display("result finished");
  endtask
  // a done pulse while the enable is low must not be captured
  task automatic t_freeze();
    clk_en_in <= 1'b0;
    value <= 12'h7e1;
    dly <= 4'h1;
    start <= 1'b1;
    @(posedge clk_sys_in);
    start <= 1'b0;
    do @(negedge clk_sys_in); while (!conv_done_in);
    check(s_axi_arready_out, 1'b0);
    check(s_axi_awready_out, 1'b0);
    @(posedge clk_sys_in);
    clk_en_in <= 1'b1;
    rd(ADDR_RESULT_HIGH, {24'h0, 8'h3c}, RESP_OKAY);
    $display("clock enable finished");
  endtask
  task automatic t_reset();
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    check(channel_code_out, 5'h0f);
    check(analog_src_out, SRC_QUARTER_VCC);
    rd(ADDR_RESULT_HIGH, 32'h0, RESP_OKAY);
    rd(ADDR_INPUT_SEL, 32'hf0, RESP_OKAY);
    $display("mid-run reset finished");
  endtask
  task automatic t_pins();
    pin_mode_field_in <= {8{8'he4}};
    @(negedge clk_sys_in);
    check(pin_analog_en_out, 32'h88888888);
    @(posedge clk_sys_in);
    pin_mode_field_in <= ~{8{8'he4}};
    @(negedge clk_sys_in);
    check(pin_analog_en_out, 32'h11111111);
    $display("pin modes finished");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    check(channel_code_out, 5'h0f);
    rd(ADDR_INPUT_SEL, 32'hf0, RESP_OKAY);
    t_channels();
    t_reference();
    t_result();
    t_freeze();
    t_pins();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire

// file: adc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        start_in,
  input  wire logic [11:0] value_in,
  input  wire logic [3:0]  delay_in,
  output logic [11:0]      result_out,
  output logic             done_out
);
  logic [3:0] cnt_r;
  // result bus churns outside the done pulse so only a true capture can match
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in) begin
      cnt_r <= '0;
      done_out <= 1'b0;
      result_out <= '0;
    end else begin
      done_out <= cnt_r == 4'h1;
      result_out <= cnt_r == 4'h1 ? value_in : ~result_out;
      if (start_in) cnt_r <= delay_in;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
endmodule
`default_nettype wire

// file: adc_sel_pkg.sv
package adc_sel_pkg;
  // register indices; each register is one aligned word, byte address four times the index
  localparam logic [7:0] OFF_RESULT_LOW  = 8'haa;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'hab;
  localparam logic [7:0] OFF_INPUT_SEL   = 8'hae;
  localparam int         ADDR_W          = 10;
  localparam logic [9:0] ADDR_RESULT_LOW  = {OFF_RESULT_LOW, 2'h0};
  localparam logic [9:0] ADDR_RESULT_HIGH = {OFF_RESULT_HIGH, 2'h0};
  localparam logic [9:0] ADDR_INPUT_SEL   = {OFF_INPUT_SEL, 2'h0};
  localparam int         SEL_BYTE_MSB    = 7;
  // input_select_register layout
  localparam int         CH_LOW_MSB      = 7;
  localparam int         CH_LOW_LSB      = 4;
  localparam int         CH_TOP_BIT      = 3;
  localparam int         REF_SRC_BIT     = 2;
  localparam int         BG_LEVEL_MSB    = 1;
  localparam int         BG_LEVEL_LSB    = 0;
  localparam logic [7:0] INPUT_SEL_RST   = 8'hf0;
  // result layout
  localparam int         RES_LOW_MSB     = 7;
  localparam int         RES_LOW_LSB     = 4;
  localparam int         RES_NIB_MSB     = 3;
  localparam int         RES_HIGH_MSB    = 11;
  localparam int         RES_HIGH_LSB    = 4;
  // channel codes
  localparam logic [4:0] CH_EXT_LO_LAST  = 5'h0b;
  localparam logic [4:0] CH_BANDGAP      = 5'h0c;
  localparam logic [4:0] CH_RSVD_A       = 5'h0d;
  localparam logic [4:0] CH_GROUND       = 5'h0e;
  localparam logic [4:0] CH_QUARTER_VCC  = 5'h0f;
  localparam logic [4:0] CH_EXT_HI_FIRST = 5'h10;
  localparam logic [4:0] CH_EXT_HI_LAST  = 5'h16;
  localparam logic [4:0] CH_RSVD_B       = 5'h17;
  // bandgap levels
  localparam logic [1:0] BG_1V22         = 2'h0;
  localparam logic [1:0] BG_2V54         = 2'h1;
  localparam logic [1:0] PIN_MODE_ANALOG = 2'h3;
  localparam int         NUM_PINS        = 32;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  localparam logic [1:0] RESP_DECERR     = 2'h3;

  typedef enum logic [1:0] {
    SRC_PIN,
    SRC_BANDGAP,
    SRC_GROUND,
    SRC_QUARTER_VCC
  } analog_src_t;
endpackage

// file: adc_sel_properties.sv
`timescale 1ns/100ps
`default_nettype none
module adc_sel_properties
  import adc_sel_pkg::*;
(
  input wire logic                  clk_sys_in,
  input wire logic                  rstn_in,
  input wire logic                  clk_en_in,
  input wire logic                  conv_done_in,
  input wire logic [11:0]           conv_result_in,
  input wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
  input wire logic                  s_axi_awvalid_in,
  input wire logic                  s_axi_awready_out,
  input wire logic [31:0]           s_axi_wdata_in,
  input wire logic [3:0]            s_axi_wstrb_in,
  input wire logic                  s_axi_wvalid_in,
  input wire logic                  s_axi_wready_out,
  input wire logic [ADDR_W-1:0]     s_axi_araddr_in,
  input wire logic                  s_axi_arvalid_in,
  input wire logic                  s_axi_arready_out,
  input wire logic [31:0]           s_axi_rdata_out,
  input wire logic                  s_axi_rvalid_out,
  input wire logic [2*NUM_PINS-1:0] pin_mode_field_in,
  input wire logic [4:0]            channel_code_out,
  input wire logic                  pin_route_en_out,
  input wire logic [4:0]            pin_index_out,
  input wire analog_src_t           analog_src_out,
  input wire logic                  reference_source_bit_out,
  input wire logic [1:0]            bandgap_level_field_out,
  input wire logic                  bandgap_level_conflict_out,
  input wire logic [NUM_PINS-1:0]   pin_analog_en_out
);
  logic [11:0]         res_r;
  logic [NUM_PINS-1:0] ana_exp;
  logic [4:0]          c;
  assign c = channel_code_out;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      ana_exp[i] = &pin_mode_field_in[2*i+:2];
    end
  end
  // shadow of the held result, frozen like the design when the enable is low
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      res_r <= '0;
    end else if (conv_done_in && clk_en_in) begin
      res_r <= conv_result_in;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence sel_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out &&
      s_axi_awaddr_in == ADDR_INPUT_SEL && s_axi_wstrb_in[0] && clk_en_in;
  endsequence
  sequence rd_taken(a);
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == a;
  endsequence
  route_select_a: assert property (
    pin_route_en_out == (c <= 5'h0b || c inside {[5'h10:5'h16]})
    && (!pin_route_en_out || pin_index_out == c)) else $error("pin routing wrong");
  source_select_a: assert property (
    analog_src_out == (c == 5'h0c ? SRC_BANDGAP : c == 5'h0f ?
    SRC_QUARTER_VCC : pin_route_en_out ? SRC_PIN : SRC_GROUND)) else $error("source wrong");
  level_conflict_a: assert property (
    bandgap_level_conflict_out == (reference_source_bit_out && bandgap_level_field_out == 2'h0))
    else $error("conflict flag wrong");
  analog_pin_a: assert property (
    pin_analog_en_out == ana_exp) else $error("pin enable wrong");
  high_read_a: assert property (
    rd_taken(ADDR_RESULT_HIGH) |=> s_axi_rvalid_out &&
    s_axi_rdata_out == {24'h0, $past(res_r[11:4])}) else $error("high result wrong");
  low_read_a: assert property (
    rd_taken(ADDR_RESULT_LOW) |=> s_axi_rvalid_out &&
    s_axi_rdata_out[7:4] == $past(res_r[3:0])) else $error("low result wrong");
  select_write_a: assert property (
    sel_taken |=> ##1 {c, reference_source_bit_out, bandgap_level_field_out} ==
    {$past(s_axi_wdata_in[3], 2), $past(s_axi_wdata_in[7:4], 2),
     $past(s_axi_wdata_in[2:0], 2)}) else $error("select write wrong");
  read_quiet_a: assert property (
    s_axi_arvalid_in && s_axi_arready_out && !s_axi_awvalid_in && !$past(s_axi_awvalid_in)
    |=> $stable({c, reference_source_bit_out, bandgap_level_field_out}))
    else $error("read disturbed select");
endmodule
bind adc_channel_ref_result_regs adc_sel_properties u_props (.*);
`default_nettype wire
